// ### ice_dispenser_panel_control.sv
`timescale 1ns/1ps
`include "ice_panel_params.svh"
module ice_dispenser_panel_control
  import ice_panel_pkg::*;
#(
  parameter int CYC_PER_MS  = `CLK_HZ / 1000,
  parameter int SEC_PER_DAY = `SEC_PER_DAY
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  input  wire logic signed [7:0]         freezer_temp,
  input  wire logic                      key_ice_form,
  input  wire logic                      key_ice_timer,
  input  wire logic                      key_ice_stop,
  input  wire logic                      key_vacation,
  input  wire logic                      key_quick_freeze,
  input  wire logic                      key_lc_select,
  input  wire logic                      dispenser_sw,
  input  wire logic                      ice_lever,
  input  wire logic                      ice_present,
  input  wire logic                      fill_step_busy,
  input  wire logic [11:0]               load_outputs,
  input  wire logic                      nv_valid,
  input  wire ice_panel_pkg::ice_form_type nv_ice_form,
  input  wire logic                      nv_quick_freeze,
  input  wire logic                      nv_vacation,
  input  wire logic signed [7:0]         nv_frz_set,
  input  wire logic signed [7:0]         nv_fresh_set,
  input  wire logic [4:0]                nv_timer_days,
  input  wire logic [4:0]                nv_timer_elapsed,
  input  wire ice_panel_pkg::filter_type nv_filter,
  input  wire logic [3:0]                nv_filter_months,
  input  wire logic [4:0]                nv_filter_days,
  output ice_panel_pkg::ice_form_type    ice_form,
  output logic                           ice_make_en,
  output logic                           gear_motor,
  output logic                           ice_solenoid,
  output logic                           cover_solenoid,
  output logic                           fresh_cool_en,
  output logic                           freezer_cool_en,
  output logic                           quick_freeze,
  output logic                           vacation,
  output logic signed [7:0]              frz_set,
  output logic signed [7:0]              fresh_set,
  output logic                           ice_timer_lamp,
  output logic                           show_days,
  output logic [4:0]                     timer_days,
  output ice_panel_pkg::filter_type      filter_led,
  output logic                           blink_all,
  output logic                           lc_active,
  output logic [11:0]                    lc_leds,
  output logic [4:0]                     nv_timer_elapsed_out,
  output logic [3:0]                     nv_filter_months_out,
  output logic [4:0]                     nv_filter_days_out
);
  import ice_panel_pkg::*;

  localparam int PULSE_MS = `SOL_PULSE_S * `MS_PER_SEC;

  typedef struct packed {
    logic         booted;
    logic [3:0]   boot_secs;
    logic         boot_done;
    ice_form_type form;
    logic         stop_pend;
    logic         qf;
    logic         vac;
    logic [7:0]   fset;
    logic [7:0]   rset;
    logic         timer_on;
    logic [4:0]   days;
    logic [4:0]   elapsed;
    logic [2:0]   show_secs;
    logic         show;
    logic [16:0]  day_secs;
    filter_type   filt;
    logic [3:0]   f_months;
    logic [4:0]   f_days;
    logic [16:0]  f_secs;
    logic [15:0]  sol_ms;
    logic         disp_d;
    logic         close_arm;
    logic [2:0]   close_secs;
    lc_state_type lc;
    logic [9:0]   lc_ms;
    logic [2:0]   blinks;
    logic [4:0]   lc_secs;
    logic         blink_on;
    logic         form_d;
    logic         tmr_d;
    logic         lcsel_d;
    logic         two_d;
  } st_type;
  st_type st_r;
  st_type st_nxt;

  logic       ms_tick;
  logic       sec_tick;
  logic [5:0] filt_hold;
  logic [5:0] lc_hold;
  logic       filt_keys;
  logic       lc_keys;

  function automatic logic rise(input logic now, input logic was);
    rise = now && !was;
  endfunction

  assign filt_keys = key_ice_form && key_ice_stop;
  assign lc_keys   = key_quick_freeze && key_vacation;

  tick_gen #(.CYC_PER_MS(CYC_PER_MS)) u_tick (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ms_tick  (ms_tick),
    .sec_tick (sec_tick)
  );

  hold_timer #(.W(6)) u_filt_hold (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .level    (filt_keys),
    .sec_tick (sec_tick),
    .secs     (filt_hold)
  );

  hold_timer #(.W(6)) u_lc_hold (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .level    (lc_keys),
    .sec_tick (sec_tick),
    .secs     (lc_hold)
  );

  always_comb begin
    logic form_p;
    logic tmr_p;
    logic expire;
    form_p = rise(key_ice_form, st_r.form_d) && !key_ice_stop;
    tmr_p  = rise(key_ice_timer, st_r.tmr_d);
    expire = 1'b0;
    st_nxt = st_r;
    st_nxt.form_d  = key_ice_form;
    st_nxt.tmr_d   = key_ice_timer;
    st_nxt.lcsel_d = key_lc_select;
    st_nxt.two_d   = filt_keys;

    // Power-up decision is taken one clock after reset release
    if (!st_r.booted) begin
      st_nxt.booted = 1'b1;
      st_nxt.filt     = nv_valid ? nv_filter : FILT_GREEN;
      st_nxt.f_months = nv_valid ? nv_filter_months : 4'h0;
      st_nxt.f_days   = nv_valid ? nv_filter_days : 5'h00;
      st_nxt.timer_on = nv_valid && (nv_timer_days != 5'h00);
      st_nxt.days     = nv_valid ? nv_timer_days : 5'h00;
      st_nxt.elapsed  = nv_valid ? nv_timer_elapsed : 5'h00;
      if (nv_valid && (freezer_temp < `WARM_LIMIT_C)) begin
        st_nxt.form = nv_ice_form;
        st_nxt.qf   = nv_quick_freeze;
        st_nxt.vac  = nv_vacation;
        st_nxt.fset = nv_frz_set;
        st_nxt.rset = nv_fresh_set;
      end else begin
        st_nxt.form     = ICE_CUBE;
        st_nxt.qf       = 1'b0;
        st_nxt.vac      = 1'b0;
        st_nxt.fset     = `FRZ_INIT_C;
        st_nxt.rset     = `FRESH_INIT_C;
        st_nxt.timer_on = 1'b0;
        st_nxt.days     = 5'h00;
      end
    end else begin
      // Decrement first so a fresh pulse load below wins
      if (st_r.sol_ms != 16'h0000 && ms_tick) begin
        st_nxt.sol_ms = st_r.sol_ms - 16'h0001;
      end
      if (!st_r.boot_done && sec_tick) begin
        st_nxt.boot_secs = st_r.boot_secs + 4'h1;
        if (st_r.boot_secs == 4'(`BOOT_PULSE_S - 1)) begin
          st_nxt.boot_done = 1'b1;
          st_nxt.sol_ms    = 16'(PULSE_MS);
        end
      end

      if (form_p && st_r.lc == LC_IDLE) begin
        if (st_r.timer_on) begin
          st_nxt.timer_on = 1'b0;
          st_nxt.show     = 1'b0;
        end else begin
          case (st_r.form)
            ICE_CUBE:    st_nxt.form = ICE_CRUSHED;
            ICE_CRUSHED: st_nxt.form = ICE_OFF;
            default:     st_nxt.form = ICE_CUBE;
          endcase
        end
      end

      if (tmr_p && st_r.lc == LC_IDLE) begin
        st_nxt.show      = 1'b1;
        st_nxt.show_secs = 3'h0;
        if (!st_r.timer_on) begin
          st_nxt.timer_on = 1'b1;
          st_nxt.form     = ICE_OFF;
          st_nxt.days     = `TIMER_MIN_DAYS;
          st_nxt.elapsed  = 5'h00;
          st_nxt.day_secs = '0;
        end else if (st_r.show) begin
          st_nxt.days = (st_r.days == `TIMER_MAX_DAYS) ? `TIMER_MIN_DAYS
                                                       : st_r.days + 5'h01;
        end
      end else if (st_r.show && sec_tick) begin
        st_nxt.show_secs = st_r.show_secs + 3'h1;
        if (st_r.show_secs == 3'(`SHOW_DAYS_S - 1)) begin
          st_nxt.show = 1'b0;
        end
      end

      // Reservation day count; stands still while unpowered by nature
      if (st_r.timer_on && sec_tick) begin
        if (st_r.day_secs == 17'(SEC_PER_DAY - 1)) begin
          st_nxt.day_secs = '0;
          st_nxt.elapsed  = st_r.elapsed + 5'h01;
          if (st_r.elapsed + 5'h01 >= st_r.days) begin
            expire          = 1'b1;
            st_nxt.timer_on = 1'b0;
            st_nxt.form     = ICE_CUBE;
          end
        end else begin
          st_nxt.day_secs = st_r.day_secs + 17'h00001;
        end
      end
      if (expire) begin
        st_nxt.vac = 1'b0;
      end

      // Filter indicator
      if (filt_hold == 6'(`FILTER_RESET_S) && sec_tick == 1'b0 && st_r.two_d) begin
        if (st_r.filt != FILT_GREEN || st_r.f_months != 4'h0 || st_r.f_days != 5'h00) begin
          st_nxt.filt     = FILT_GREEN;
          st_nxt.f_months = 4'h0;
          st_nxt.f_days   = 5'h00;
          st_nxt.f_secs   = '0;
        end
      end else if (filt_hold == 6'(`FILTER_OFF_S) && st_r.filt != FILT_OFF) begin
        st_nxt.filt = FILT_OFF;
      end else if (st_r.filt != FILT_OFF && sec_tick) begin
        if (st_r.f_secs == 17'(SEC_PER_DAY - 1)) begin
          st_nxt.f_secs = '0;
          if (st_r.f_days == 5'(`DAYS_PER_MONTH - 1)) begin
            st_nxt.f_days = 5'h00;
            if (st_r.f_months != 4'hF) begin
              st_nxt.f_months = st_r.f_months + 4'h1;
            end
          end else begin
            st_nxt.f_days = st_r.f_days + 5'h01;
          end
        end else begin
          st_nxt.f_secs = st_r.f_secs + 17'h00001;
        end
        if (st_r.f_months >= `RED_MONTHS) begin
          st_nxt.filt = FILT_RED;
        end else if (st_r.f_months >= `ORANGE_MONTHS) begin
          st_nxt.filt = FILT_ORANGE;
        end else begin
          st_nxt.filt = FILT_GREEN;
        end
      end

      // Stop-after-fill latch
      // Only a fill already running when off is chosen may finish
      if (st_nxt.form == ICE_OFF) begin
        st_nxt.stop_pend = fill_step_busy && (st_r.form != ICE_OFF || st_r.stop_pend);
      end else begin
        st_nxt.stop_pend = 1'b0;
      end

      // Cover solenoid timing
      st_nxt.disp_d = dispenser_sw;
      if (st_r.disp_d && !dispenser_sw) begin
        st_nxt.close_arm  = 1'b1;
        st_nxt.close_secs = 3'h0;
      end else if (dispenser_sw) begin
        st_nxt.close_arm = 1'b0;
      end else if (st_r.close_arm && !gear_motor && sec_tick) begin
        st_nxt.close_secs = st_r.close_secs + 3'h1;
        if (st_r.close_secs == 3'(`CLOSE_DELAY_S - 1)) begin
          st_nxt.close_arm = 1'b0;
          st_nxt.sol_ms    = 16'(PULSE_MS);
        end
      end
      // Load-check sequence
      case (st_r.lc)
        LC_IDLE: begin
          if (lc_hold == 6'(`LOAD_HOLD_S)) begin
            st_nxt.lc = LC_ARMED;
          end
        end
        LC_ARMED: begin
          if (!lc_keys) begin
            st_nxt.lc       = LC_BLINK;
            st_nxt.lc_ms    = '0;
            st_nxt.blinks   = 3'h0;
            st_nxt.blink_on = 1'b1;
          end
        end
        LC_BLINK: begin
          if (rise(key_lc_select, st_r.lcsel_d)) begin
            st_nxt.lc      = LC_SHOW;
            st_nxt.lc_secs = 5'h00;
          end else if (ms_tick) begin
            if (st_r.lc_ms == 10'(`BLINK_HALF_MS - 1)) begin
              st_nxt.lc_ms    = '0;
              st_nxt.blink_on = !st_r.blink_on;
              st_nxt.blinks   = st_r.blinks + 3'h1;
              if (st_r.blinks == 3'(`BLINK_TOTAL - 1)) begin
                st_nxt.lc = LC_IDLE;
              end
            end else begin
              st_nxt.lc_ms = st_r.lc_ms + 10'h001;
            end
          end
        end
        default: begin
          if (sec_tick) begin
            st_nxt.lc_secs = st_r.lc_secs + 5'h01;
            if (st_r.lc_secs == 5'(`LOAD_CHECK_S - 1)) begin
              st_nxt.lc = LC_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    logic dispense;
    dispense     = st_r.booted && ice_lever && ice_present;
    gear_motor   = dispense;
    ice_solenoid = dispense && st_r.form == ICE_CUBE;
  end

  assign ice_form        = st_r.form;
  // Production also resumes early when the reservation is near its end
  assign ice_make_en     = st_r.booted && !st_r.vac &&
                           ((st_r.form != ICE_OFF) || st_r.stop_pend ||
                            (st_r.timer_on &&
                             (st_r.elapsed + `RESUME_LEAD_DAYS >= st_r.days)));
  assign cover_solenoid  = st_r.sol_ms != 16'h0000;
  assign fresh_cool_en   = st_r.booted && !st_r.vac;
  assign freezer_cool_en = st_r.booted;
  assign quick_freeze    = st_r.qf;
  assign vacation        = st_r.vac;
  assign frz_set         = st_r.fset;
  assign fresh_set       = st_r.rset;
  assign ice_timer_lamp  = st_r.timer_on;
  assign show_days       = st_r.show;
  assign timer_days      = st_r.days;
  assign filter_led      = st_r.filt;
  assign blink_all       = (st_r.lc == LC_ARMED) || (st_r.lc == LC_BLINK && st_r.blink_on);
  assign lc_active       = st_r.lc == LC_SHOW;
  assign lc_leds         = (st_r.lc == LC_SHOW) ? load_outputs : 12'h000;
  assign nv_timer_elapsed_out = st_r.elapsed;
  assign nv_filter_months_out = st_r.f_months;
  assign nv_filter_days_out   = st_r.f_days;
endmodule

// ### ice_panel_params.svh
`ifndef ICE_PANEL_PARAMS_SVH
`define ICE_PANEL_PARAMS_SVH

// Timebase
`define CLK_HZ            50000000
`define MS_PER_SEC        1000
// Temperatures in whole degrees C, signed 8 bit
`define WARM_LIMIT_C      8'sh05
`define FRZ_INIT_C        8'shEC
`define FRESH_INIT_C      8'sh03
// Times in seconds; BLINK_HALF_MS in milliseconds, BLINK_TOTAL a count
`define BOOT_PULSE_S      8
`define CLOSE_DELAY_S     5
`define SHOW_DAYS_S       5
`define FILTER_OFF_S      5
`define LOAD_HOLD_S       6
`define FILTER_RESET_S    25
`define SOL_PULSE_S       1
`define LOAD_CHECK_S      30
`define BLINK_HALF_MS     500
`define BLINK_TOTAL       4
// Day and month figures
`define SEC_PER_DAY       86400
`define DAYS_PER_MONTH    30
`define TIMER_MIN_DAYS    5'h03
`define TIMER_MAX_DAYS    5'h1E
`define RESUME_LEAD_DAYS  5'h02
`define ORANGE_MONTHS     4'h5
`define RED_MONTHS        4'h6

`endif

// ### ice_panel_pkg.sv
package ice_panel_pkg;
  typedef enum logic [1:0] {ICE_CUBE, ICE_CRUSHED, ICE_OFF} ice_form_type;
  typedef enum logic [1:0] {FILT_OFF, FILT_GREEN, FILT_ORANGE, FILT_RED} filter_type;
  typedef enum logic [1:0] {LC_IDLE, LC_ARMED, LC_BLINK, LC_SHOW} lc_state_type;
endpackage

// ### tick_gen.sv
`timescale 1ns/1ps
`include "ice_panel_params.svh"
// Free divider: one-cycle pulses per millisecond and per second
module tick_gen #(
  parameter int CYC_PER_MS = `CLK_HZ / 1000
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  output logic      ms_tick,
  output logic      sec_tick
);
  typedef struct packed {
    logic [31:0] cyc;
    logic [15:0] ms;
    logic        ms_p;
    logic        sec_p;
  } st_type;
  st_type st_r;
  st_type st_nxt;

  always_comb begin
    st_nxt       = st_r;
    st_nxt.ms_p  = 1'b0;
    st_nxt.sec_p = 1'b0;
    if (st_r.cyc == 32'(CYC_PER_MS - 1)) begin
      st_nxt.cyc  = '0;
      st_nxt.ms_p = 1'b1;
      if (st_r.ms == 16'(`MS_PER_SEC - 1)) begin
        st_nxt.ms    = '0;
        st_nxt.sec_p = 1'b1;
      end else begin
        st_nxt.ms = st_r.ms + 16'h0001;
      end
    end else begin
      st_nxt.cyc = st_r.cyc + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ms_tick  = st_r.ms_p;
  assign sec_tick = st_r.sec_p;
endmodule

// ### hold_timer.sv
`timescale 1ns/1ps
`include "ice_panel_params.svh"
// Counts whole seconds a level has been held; cleared when it drops
module hold_timer #(
  parameter int W = 6
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         level,
  input  wire logic         sec_tick,
  output logic [W-1:0]      secs
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } st_type;
  st_type st_r;
  st_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!level) begin
      st_nxt.cnt = '0;
    end else if (sec_tick && (st_r.cnt != {W{1'b1}})) begin
      st_nxt.cnt = st_r.cnt + W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign secs = st_r.cnt;
endmodule

// ### ice_panel_nv_model.sv
`timescale 1ns/1ps
// Stored panel image as the nonvolatile memory hands it back at power-up
module ice_panel_nv_model
  import ice_panel_pkg::*;
(
  output logic                       nv_valid,
  output ice_panel_pkg::ice_form_type nv_ice_form,
  output logic                       nv_quick_freeze,
  output logic                       nv_vacation,
  output logic signed [7:0]          nv_frz_set,
  output logic signed [7:0]          nv_fresh_set,
  output logic [4:0]                 nv_timer_days,
  output logic [4:0]                 nv_timer_elapsed,
  output ice_panel_pkg::filter_type  nv_filter,
  output logic [3:0]                 nv_filter_months,
  output logic [4:0]                 nv_filter_days
);
  // Settings saved before the outage
  assign nv_valid        = 1'b1;
  assign nv_ice_form     = ICE_CRUSHED;
  assign nv_quick_freeze = 1'b1;
  assign nv_vacation     = 1'b1;
  assign nv_frz_set      = 8'shEA;
  assign nv_fresh_set    = 8'sh04;
  // Long reservation, so it never expires within one run
  assign nv_timer_days    = 5'h1E;
  assign nv_timer_elapsed = 5'h00;
  // Filter image frozen while unpowered
  assign nv_filter        = FILT_ORANGE;
  assign nv_filter_months = 4'h5;
  assign nv_filter_days   = 5'h02;
endmodule

// ### ice_panel_checker_sva.sv
`timescale 1ns/1ps
module ice_panel_checker
  import ice_panel_pkg::*;
#(
  parameter int CYC_PER_MS  = 4,
  parameter int SEC_PER_DAY = 3
) (
  input wire logic                       core_clk,
  input wire logic                       rst_n,
  input wire logic                       key_ice_form,
  input wire logic                       key_ice_timer,
  input wire logic                       key_ice_stop,
  input wire logic                       ice_lever,
  input wire logic                       ice_present,
  input wire ice_panel_pkg::ice_form_type ice_form,
  input wire logic                       gear_motor,
  input wire logic                       ice_solenoid,
  input wire logic                       cover_solenoid,
  input wire logic                       fresh_cool_en,
  input wire logic                       freezer_cool_en,
  input wire logic                       ice_make_en,
  input wire logic                       vacation,
  input wire logic                       ice_timer_lamp,
  input wire logic                       show_days,
  input wire logic [4:0]                 timer_days,
  input wire logic                       blink_all,
  input wire logic                       lc_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Keys are refused during load check
  logic busy;
  assign busy = lc_active | blink_all;
  a_crushed_gear: assert property (ice_form == ICE_CRUSHED && ice_lever && ice_present
    |-> gear_motor && !ice_solenoid) else $error("crushed dispense drive wrong");
  a_cube_both: assert property (ice_form == ICE_CUBE && ice_lever && ice_present
    |-> gear_motor && ice_solenoid) else $error("cube dispense drive wrong");
  a_off_lever: assert property (ice_form == ICE_OFF && ice_lever && ice_present
    |-> gear_motor) else $error("lever ignored with ice making off");
  a_form_step: assert property ($rose(key_ice_form) && !key_ice_stop && !busy
    && !ice_timer_lamp && ice_form == ICE_CUBE |=> ice_form == ICE_CRUSHED)
    else $error("form key did not advance cube");
  a_form_cancel: assert property ($rose(key_ice_form) && !key_ice_stop && !busy
    && ice_timer_lamp |=> !ice_timer_lamp) else $error("form key kept timer");
  a_timer_first: assert property ($rose(key_ice_timer) && !busy && !ice_timer_lamp
    |=> ice_timer_lamp && timer_days == 5'h03 && ice_form == ICE_OFF)
    else $error("first timer press wrong");
  a_timer_wrap: assert property ($rose(key_ice_timer) && !busy && ice_timer_lamp
    && show_days && timer_days == 5'h1E |=> timer_days == 5'h03) else $error("timer did not wrap");
  a_vacation_cool: assert property (vacation [*3]
    |-> !fresh_cool_en && freezer_cool_en && !ice_make_en) else $error("vacation cooling wrong");
  a_cover_hold: assert property ($rose(cover_solenoid) |-> cover_solenoid [*8])
    else $error("cover pulse too short");
endmodule

bind ice_dispenser_panel_control ice_panel_checker #(
  .CYC_PER_MS  (CYC_PER_MS),
  .SEC_PER_DAY (SEC_PER_DAY)
) i_chk (
  .core_clk(core_clk), .rst_n(rst_n), .key_ice_form(key_ice_form),
  .key_ice_timer(key_ice_timer), .key_ice_stop(key_ice_stop), .ice_lever(ice_lever),
  .ice_present(ice_present), .ice_form(ice_form), .gear_motor(gear_motor),
  .ice_solenoid(ice_solenoid), .cover_solenoid(cover_solenoid),
  .fresh_cool_en(fresh_cool_en), .freezer_cool_en(freezer_cool_en),
  .ice_make_en(ice_make_en), .vacation(vacation), .ice_timer_lamp(ice_timer_lamp),
  .timer_days(timer_days), .blink_all(blink_all), .lc_active(lc_active),
  .show_days(show_days)
);

// ### test_ice_dispenser_panel_control.sv
`timescale 1ns/1ps
module test_ice_dispenser_panel_control;
  import ice_panel_pkg::*;
  localparam int CPS = 4000;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic signed [7:0] freezer_temp = 8'sh14;
  logic key_ice_form = 1'b0, key_ice_timer = 1'b0, key_ice_stop = 1'b0;
  logic dispenser_sw = 1'b0, ice_lever = 1'b0, ice_present = 1'b0;
  logic key_vacation = 1'b0, key_quick_freeze = 1'b0, key_lc_select = 1'b0, fill_step_busy = 1'b0;
  logic [11:0] load_outputs = 12'h000;
  logic [11:0] lc_leds;
  logic blink_all, lc_active;
  logic nv_valid, nv_quick_freeze, nv_vacation;
  ice_form_type nv_ice_form, ice_form;
  filter_type nv_filter, filter_led;
  logic signed [7:0] nv_frz_set, nv_fresh_set, frz_set, fresh_set;
  logic [4:0] nv_timer_days, nv_timer_elapsed, nv_filter_days, timer_days;
  logic [3:0] nv_filter_months;
  logic ice_make_en, gear_motor, ice_solenoid, cover_solenoid, fresh_cool_en;
  logic freezer_cool_en, quick_freeze, vacation, ice_timer_lamp, show_days;
  int n_errors = 0;
  int checked = 0;
  int fm, d, n, w;

  always #10 core_clk = ~core_clk;

  ice_panel_nv_model i_nv (.nv_valid(nv_valid), .nv_ice_form(nv_ice_form),
    .nv_quick_freeze(nv_quick_freeze), .nv_vacation(nv_vacation), .nv_frz_set(nv_frz_set),
    .nv_fresh_set(nv_fresh_set), .nv_timer_days(nv_timer_days),
    .nv_timer_elapsed(nv_timer_elapsed), .nv_filter(nv_filter),
    .nv_filter_months(nv_filter_months), .nv_filter_days(nv_filter_days));

  ice_dispenser_panel_control #(.CYC_PER_MS(4), .SEC_PER_DAY(3)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .freezer_temp(freezer_temp),
    .key_ice_form(key_ice_form), .key_ice_timer(key_ice_timer), .key_ice_stop(key_ice_stop),
    .key_vacation(key_vacation), .key_quick_freeze(key_quick_freeze),
    .key_lc_select(key_lc_select),
    .dispenser_sw(dispenser_sw), .ice_lever(ice_lever), .ice_present(ice_present),
    .fill_step_busy(fill_step_busy), .load_outputs(load_outputs), .nv_valid(nv_valid),
    .nv_ice_form(nv_ice_form), .nv_quick_freeze(nv_quick_freeze), .nv_vacation(nv_vacation),
    .nv_frz_set(nv_frz_set), .nv_fresh_set(nv_fresh_set), .nv_timer_days(nv_timer_days),
    .nv_timer_elapsed(nv_timer_elapsed), .nv_filter(nv_filter),
    .nv_filter_months(nv_filter_months), .nv_filter_days(nv_filter_days),
    .ice_form(ice_form), .ice_make_en(ice_make_en), .gear_motor(gear_motor),
    .ice_solenoid(ice_solenoid), .cover_solenoid(cover_solenoid),
    .fresh_cool_en(fresh_cool_en), .freezer_cool_en(freezer_cool_en),
    .quick_freeze(quick_freeze), .vacation(vacation), .frz_set(frz_set),
    .fresh_set(fresh_set), .ice_timer_lamp(ice_timer_lamp), .show_days(show_days),
    .timer_days(timer_days), .filter_led(filter_led), .blink_all(blink_all),
    .lc_active(lc_active), .lc_leds(lc_leds), .nv_timer_elapsed_out(),
    .nv_filter_months_out(), .nv_filter_days_out());

  task automatic summarize();
    if (n_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  // Seconds rounded, since tick phase is free running
  task automatic chk_sec(input int cycles, input int secs);
    checked++;
    if ((cycles + CPS / 2) / CPS != secs) begin
      n_errors++;
      $display("[FAIL] %0t got %0h exp %0h", $time, cycles, secs * CPS);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #2;
  endtask

  task automatic press(input int k);
    if (k == 0) begin
      key_ice_form = 1'b1;
    end else begin
      key_ice_timer = 1'b1;
    end
    cyc(2);
    key_ice_form = 1'b0;
    key_ice_timer = 1'b0;
    cyc(2);
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    cyc(20);
    rst_n = 1'b1;
    cyc(3);
  endtask

  task automatic wait_for(input int sel, output int k);
    k = 0;
    while (!(sel == 0 ? cover_solenoid === 1'b1 :
             sel == 1 ? filter_led === FILT_OFF : blink_all === 1'b1)) begin
      cyc(1);
      k++;
      if (k > 12 * CPS) begin
        n_errors++;
        summarize();
      end
    end
  endtask

  initial begin
    void'($urandom(43));
    freezer_temp = 8'(5 + $urandom % 60);
    load_outputs = 12'($urandom);
    do_reset();
    chk(12'(ice_form), 12'h000);
    chk({4'h0, frz_set}, 12'h0EC);
    chk({4'h0, fresh_set}, 12'h003);
    chk({10'h0, vacation, quick_freeze}, 12'h000);
    chk({11'h0, ice_timer_lamp}, 12'h000);
    chk(12'(filter_led), 12'(FILT_ORANGE));
    fm = 0;
    ice_present = 1'b1;
    for (int i = 0; i < 4; i++) begin
      ice_lever = 1'b1;
      cyc(1);
      chk({10'h0, gear_motor, ice_solenoid}, fm == 0 ? 12'h003 : 12'h002);
      ice_lever = 1'b0;
      press(0);
      fm = (fm + 1) % 3;
      chk(12'(ice_form), 12'(fm));
    end
    fill_step_busy = 1'b1;
    press(0);
    chk({11'h0, ice_make_en}, 12'h001);
    fill_step_busy = 1'b0;
    cyc(1);
    chk({11'h0, ice_make_en}, 12'h000);
    d = 0;
    n = 1 + $urandom % 40;
    for (int i = 0; i < n; i++) begin
      press(1);
      d = (d == 0 || d == 30) ? 3 : d + 1;
      chk({7'h0, timer_days}, 12'(d));
    end
    chk({9'h0, ice_timer_lamp, show_days, 1'b0}, 12'h006);
    chk(12'(ice_form), 12'(ICE_OFF));
    press(0);
    chk({11'h0, ice_timer_lamp}, 12'h000);
    freezer_temp = -8'sd18;
    do_reset();
    chk({4'h0, frz_set}, 12'h0EA);
    chk({4'h0, fresh_set}, 12'h004);
    chk({10'h0, vacation, quick_freeze}, 12'h003);
    chk({7'h0, timer_days}, 12'h01E);
    chk(12'(ice_form), 12'(ICE_CRUSHED));
    cyc(3);
    chk({9'h0, fresh_cool_en, freezer_cool_en, ice_make_en}, 12'h002);
    wait_for(0, n);
    chk_sec(n + 3, 8);
    w = 0;
    while (cover_solenoid === 1'b1 && w < 3 * CPS) begin
      cyc(1);
      w++;
    end
    chk_sec(w, 1);
    dispenser_sw = 1'b1;
    cyc(5);
    dispenser_sw = 1'b0;
    wait_for(0, n);
    chk_sec(n, 5);
    key_ice_stop = 1'b1;
    cyc(2);
    key_ice_form = 1'b1;
    key_quick_freeze = 1'b1;
    key_vacation = 1'b1;
    wait_for(1, n);
    chk_sec(n, 5);
    key_ice_form = 1'b0;
    key_ice_stop = 1'b0;
    wait_for(2, w);
    chk_sec(n + w, 6);
    key_quick_freeze = 1'b0;
    key_vacation = 1'b0;
    cyc(2);
    chk({10'h0, blink_all, lc_active}, 12'h002);
    key_lc_select = 1'b1;
    cyc(2);
    key_lc_select = 1'b0;
    chk({10'h0, blink_all, lc_active}, 12'h001);
    chk(lc_leds, load_outputs);
    cyc(4);
    summarize();
  end
endmodule
